// >>> design/ifmb_regs.vh
// register offsets, field positions and reset values of the interrupt flag/mask bank
// assumes word addressing on a plain strobe port, 16-bit data
`ifndef IFMB_REGS_VH
`define IFMB_REGS_VH

`define IFMB_ADDR_W 4
`define IFMB_OFS_FLAGS 4'h0
`define IFMB_OFS_MASK 4'h1
`define IFMB_OFS_SELECT 4'h2
`define IFMB_OFS_EVT_STATUS 4'h3
`define IFMB_OFS_EVT_MASK 4'h4

`define IFMB_BIT_EXT0 0
`define IFMB_BIT_EXT1 1
`define IFMB_BIT_EXT2 2
`define IFMB_BIT_TMRA 3
`define IFMB_BIT_SPA_RX 4
`define IFMB_BIT_SPA_TX 5
`define IFMB_BIT_DMA1 6
`define IFMB_BIT_SHR7 7
`define IFMB_BIT_EXT3 8
`define IFMB_BIT_HOST 9
`define IFMB_BIT_SHR10 10
`define IFMB_BIT_SHR11 11
`define IFMB_BIT_DMA5 12
`define IFMB_BIT_DMA6 13

// writable/implemented bits: 15..14 reserved
`define IFMB_IMPL_MASK 16'h3FFF
`define IFMB_FLAGS_RST 16'h0000
`define IFMB_MASK_RST 16'h0000
// select bits: 0 -> bit 6, 1 -> bit 7, 2 -> bit 10, 3 -> bit 11; 1 chooses dma
`define IFMB_SELECT_RST 4'h0
`define IFMB_SEL_W 4
`define IFMB_EVT_RST 2'h0

`endif

// >>> design/ifmb_bank.v
// interrupt flag and mask register pair with dma/peripheral source sharing
// assumes all sources are synchronous to clk_sys and pulse or hold high for an event
//
// Summary of operation
// R1: flags and mask share one bit layout, each position naming the same source in both.
// R2: bits 15 and 14 of both registers are reserved and carry no source.
// R3: bit 13 holds the sixth dma channel interrupt.
// R4: bit 12 holds the fifth dma channel interrupt.
// R5: bit 11 holds serial port b transmit or the fourth dma channel, per the dma select.
// R6: bit 10 holds serial port b receive or the third dma channel, per the dma select.
// R7: bit 9 holds the host port interrupt.
// R8: bit 8 holds the fourth external interrupt.
// R9: bit 7 holds timer b or the second dma channel, per the dma select.
// R10: bit 6 is reserved or the first dma channel, per the dma select.
// R11: bit 5 holds serial port a transmit.
// R12: bit 4 holds serial port a receive.
// R13: bit 3 holds timer a.
// R14: bits 2, 1 and 0 hold the third, second and first external interrupts.
// R15: after reset every shared position selects its non-dma source.
// R16: a selected source event sets its flag, and a request goes out while flag and mask are set.
// R17: reserved positions read zero and ignore writes in flags and mask.
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "ifmb_regs.vh"

module ifmb_bank
(
    // clock, reset, enable
    input wire clk_sys,
    input wire arst_n,
    input wire clk_en,
    // register port
    input wire [`IFMB_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    // interrupt sources
    input wire ext_irq_first,
    input wire ext_irq_second,
    input wire ext_irq_third,
    input wire ext_irq_fourth,
    input wire timer_a_irq,
    input wire timer_b_irq,
    input wire serial_port_a_rx_irq,
    input wire serial_port_a_tx_irq,
    input wire serial_port_b_rx_irq,
    input wire serial_port_b_tx_irq,
    input wire host_port_irq,
    input wire dma_chan_first_irq,
    input wire dma_chan_second_irq,
    input wire dma_chan_third_irq,
    input wire dma_chan_fourth_irq,
    input wire dma_chan_fifth_irq,
    input wire dma_chan_sixth_irq,
    // core side
    output wire [15:0] core_irq_req,
    output wire core_irq_any,
    output wire irq_out
);

    // register state
    reg [15:0] flags_q;
    reg [15:0] flags_d;
    reg [15:0] mask_q;
    reg [15:0] mask_d;
    reg [`IFMB_SEL_W-1:0] dma_priority_enable_control_q;
    reg [`IFMB_SEL_W-1:0] dma_priority_enable_control_d;
    reg [1:0] evt_status_q;
    reg [1:0] evt_status_d;
    reg [1:0] evt_mask_q;
    reg [1:0] evt_mask_d;
    reg [15:0] rdata_d;
    // decoded sources and strobes
    reg [15:0] src_evt;
    wire [15:0] impl_now;
    wire [15:0] flag_clr;
    wire [15:0] pending;
    wire wr_flags;
    wire wr_mask;
    wire wr_select;
    wire wr_evt_mask;
    wire rd_evt;
    wire new_pending;
    wire unmasked_evt;
    wire [1:0] evt_set;

    // shared position: 1 in the select picks the dma channel
    function pick_src;
        input sel;
        input dma_src;
        input periph_src;
        begin
            if (sel)
            begin
                pick_src = dma_src;
            end
            else
            begin
                pick_src = periph_src;
            end
        end
    endfunction

    // reserved bit 6 also holds no mask while not routed to dma
    function [15:0] impl_bits;
        input [`IFMB_SEL_W-1:0] sel;
        begin
            impl_bits = `IFMB_IMPL_MASK;
            impl_bits[`IFMB_BIT_DMA1] = sel[0];
        end
    endfunction

    // one flag bit: a write of 1 clears, an event sets, and the set wins
    function flag_next;
        input old;
        input clr;
        input evt;
        input impl;
        begin
            flag_next = ((old & ~clr) | evt) & impl;
        end
    endfunction

    // one mask bit: written or held, and kept at 0 where no source is routed
    function mask_next;
        input old;
        input wr;
        input val;
        input impl;
        begin
            if (wr)
            begin
                mask_next = val & impl;
            end
            else
            begin
                mask_next = old & impl;
            end
        end
    endfunction

    // map each source to its bit position
    always @*
    begin
        src_evt = 16'h0000; // R2
        src_evt[`IFMB_BIT_EXT0] = ext_irq_first; // R14
        src_evt[`IFMB_BIT_EXT1] = ext_irq_second; // R14
        src_evt[`IFMB_BIT_EXT2] = ext_irq_third; // R14
        src_evt[`IFMB_BIT_TMRA] = timer_a_irq; // R13
        src_evt[`IFMB_BIT_SPA_RX] = serial_port_a_rx_irq; // R12
        src_evt[`IFMB_BIT_SPA_TX] = serial_port_a_tx_irq; // R11
        // position 6 is reserved unless dma chosen
        src_evt[`IFMB_BIT_DMA1] = pick_src(dma_priority_enable_control_q[0],
            dma_chan_first_irq, 1'b0); // R10
        src_evt[`IFMB_BIT_SHR7] = pick_src(dma_priority_enable_control_q[1],
            dma_chan_second_irq, timer_b_irq); // R9
        src_evt[`IFMB_BIT_EXT3] = ext_irq_fourth; // R8
        src_evt[`IFMB_BIT_HOST] = host_port_irq; // R7
        src_evt[`IFMB_BIT_SHR10] = pick_src(dma_priority_enable_control_q[2],
            dma_chan_third_irq, serial_port_b_rx_irq); // R6
        src_evt[`IFMB_BIT_SHR11] = pick_src(dma_priority_enable_control_q[3],
            dma_chan_fourth_irq, serial_port_b_tx_irq); // R5
        src_evt[`IFMB_BIT_DMA5] = dma_chan_fifth_irq; // R4
        src_evt[`IFMB_BIT_DMA6] = dma_chan_sixth_irq; // R3
    end

    assign impl_now = impl_bits(dma_priority_enable_control_q); // R17
    assign wr_flags = reg_wr && (reg_addr == `IFMB_OFS_FLAGS);
    assign wr_mask = reg_wr && (reg_addr == `IFMB_OFS_MASK);
    assign wr_select = reg_wr && (reg_addr == `IFMB_OFS_SELECT);
    assign wr_evt_mask = reg_wr && (reg_addr == `IFMB_OFS_EVT_MASK);
    assign rd_evt = reg_rd && (reg_addr == `IFMB_OFS_EVT_STATUS);
    assign flag_clr = wr_flags ? reg_wdata : 16'h0000;

    // flags: writing 1 clears a flag; a source event in the same cycle wins
    always @*
    begin
        flags_d = 16'h0000; // R2 R17
        flags_d[0] = flag_next(flags_q[0], flag_clr[0], src_evt[0], impl_now[0]); // R16
        flags_d[1] = flag_next(flags_q[1], flag_clr[1], src_evt[1], impl_now[1]); // R16
        flags_d[2] = flag_next(flags_q[2], flag_clr[2], src_evt[2], impl_now[2]); // R16
        flags_d[3] = flag_next(flags_q[3], flag_clr[3], src_evt[3], impl_now[3]); // R16
        flags_d[4] = flag_next(flags_q[4], flag_clr[4], src_evt[4], impl_now[4]); // R16
        flags_d[5] = flag_next(flags_q[5], flag_clr[5], src_evt[5], impl_now[5]); // R16
        flags_d[6] = flag_next(flags_q[6], flag_clr[6], src_evt[6], impl_now[6]); // R10 R16
        flags_d[7] = flag_next(flags_q[7], flag_clr[7], src_evt[7], impl_now[7]); // R16
        flags_d[8] = flag_next(flags_q[8], flag_clr[8], src_evt[8], impl_now[8]); // R16
        flags_d[9] = flag_next(flags_q[9], flag_clr[9], src_evt[9], impl_now[9]); // R16
        flags_d[10] = flag_next(flags_q[10], flag_clr[10], src_evt[10], impl_now[10]); // R16
        flags_d[11] = flag_next(flags_q[11], flag_clr[11], src_evt[11], impl_now[11]); // R16
        flags_d[12] = flag_next(flags_q[12], flag_clr[12], src_evt[12], impl_now[12]); // R16
        flags_d[13] = flag_next(flags_q[13], flag_clr[13], src_evt[13], impl_now[13]); // R16
    end

    // mask: same layout as the flags
    always @*
    begin
        mask_d = 16'h0000; // R1 R17
        mask_d[0] = mask_next(mask_q[0], wr_mask, reg_wdata[0], impl_now[0]);
        mask_d[1] = mask_next(mask_q[1], wr_mask, reg_wdata[1], impl_now[1]);
        mask_d[2] = mask_next(mask_q[2], wr_mask, reg_wdata[2], impl_now[2]);
        mask_d[3] = mask_next(mask_q[3], wr_mask, reg_wdata[3], impl_now[3]);
        mask_d[4] = mask_next(mask_q[4], wr_mask, reg_wdata[4], impl_now[4]);
        mask_d[5] = mask_next(mask_q[5], wr_mask, reg_wdata[5], impl_now[5]);
        mask_d[6] = mask_next(mask_q[6], wr_mask, reg_wdata[6], impl_now[6]); // R10
        mask_d[7] = mask_next(mask_q[7], wr_mask, reg_wdata[7], impl_now[7]);
        mask_d[8] = mask_next(mask_q[8], wr_mask, reg_wdata[8], impl_now[8]);
        mask_d[9] = mask_next(mask_q[9], wr_mask, reg_wdata[9], impl_now[9]);
        mask_d[10] = mask_next(mask_q[10], wr_mask, reg_wdata[10], impl_now[10]);
        mask_d[11] = mask_next(mask_q[11], wr_mask, reg_wdata[11], impl_now[11]);
        mask_d[12] = mask_next(mask_q[12], wr_mask, reg_wdata[12], impl_now[12]);
        mask_d[13] = mask_next(mask_q[13], wr_mask, reg_wdata[13], impl_now[13]);
    end

    always @*
    begin
        dma_priority_enable_control_d = dma_priority_enable_control_q;
        if (wr_select)
        begin
            dma_priority_enable_control_d = reg_wdata[`IFMB_SEL_W-1:0];
        end
    end

    always @*
    begin
        evt_mask_d = evt_mask_q;
        if (wr_evt_mask)
        begin
            evt_mask_d = reg_wdata[1:0];
        end
    end

    assign pending = flags_q & mask_q; // R1 R16
    assign new_pending = |(src_evt & mask_q & ~flags_q);
    assign unmasked_evt = |(src_evt & ~mask_q & impl_now);
    // event 0: a newly pending masked source, event 1: a source seen while unmasked
    assign evt_set = {unmasked_evt, new_pending};

    // event status: a read clears it, an event in the same cycle wins
    always @*
    begin
        evt_status_d = evt_status_q;
        if (rd_evt)
        begin
            evt_status_d = 2'h0;
        end
        evt_status_d = evt_status_d | evt_set;
    end

    // read data stand for the one cycle after the strobe, else 0
    always @*
    begin
        rdata_d = 16'h0000;
        if (reg_rd)
        begin
            case (reg_addr)
                `IFMB_OFS_FLAGS: rdata_d = flags_q;
                `IFMB_OFS_MASK: rdata_d = mask_q;
                `IFMB_OFS_SELECT: rdata_d = {12'h000, dma_priority_enable_control_q};
                `IFMB_OFS_EVT_STATUS: rdata_d = {14'h0, evt_status_q};
                `IFMB_OFS_EVT_MASK: rdata_d = {14'h0, evt_mask_q};
                default: rdata_d = 16'h0000; // R17
            endcase
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags_q <= `IFMB_FLAGS_RST;
        end
        else if (clk_en)
        begin
            flags_q <= flags_d;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            mask_q <= `IFMB_MASK_RST;
        end
        else if (clk_en)
        begin
            mask_q <= mask_d;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dma_priority_enable_control_q <= `IFMB_SELECT_RST; // R15
        end
        else if (clk_en)
        begin
            dma_priority_enable_control_q <= dma_priority_enable_control_d;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            evt_status_q <= `IFMB_EVT_RST;
        end
        else if (clk_en)
        begin
            evt_status_q <= evt_status_d;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            evt_mask_q <= `IFMB_EVT_RST;
        end
        else if (clk_en)
        begin
            evt_mask_q <= evt_mask_d;
        end
    end

    always @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            reg_rdata <= 16'h0000;
        end
        else if (clk_en)
        begin
            reg_rdata <= rdata_d;
        end
    end

    // core side levels
    assign core_irq_req = pending; // R16
    assign core_irq_any = |pending; // R16
    assign irq_out = |(evt_status_q & evt_mask_q);

endmodule // ifmb_bank

// >>> sim/ifmb_src_model.sv
// far-side peripherals: each requested source line pulses one cycle
// requests change just after rising edges of clk_sys
`timescale 1ns/1ps
module ifmb_src_model
(
    // clock, requests and source lines
    input wire clk_sys,
    input wire [16:0] fire,
    output logic [16:0] src_q = 17'h00000
);
    always @(posedge clk_sys)
        src_q <= fire;
endmodule // ifmb_src_model

// >>> sim/ifmb_chk_checker.sv
// port checker of the flag/mask bank
// bound onto ifmb_bank, one clock domain
`timescale 1ns/1ps
module ifmb_chk
(
    // watched ports
    input wire clk_sys, arst_n, reg_wr, reg_rd, ext_irq_first, dma_chan_first_irq, core_irq_any,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_rdata, core_irq_req
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    a_resv_zero: assert property (core_irq_req[15:14] == 2'h0) else $error("resv req");
    a_any_or: assert property (core_irq_any == |core_irq_req) else $error("any req");
    a_idle_rd: assert property ((!reg_rd || reg_addr > 4'h4) |=> reg_rdata == 16'h0000)
        else $error("rdata not zero");
    a_resv_rd: assert property (reg_rd && reg_addr < 4'h2 |=> reg_rdata[15:14] == 2'h0)
        else $error("resv read");
    a_bit13_hold: assert property (core_irq_req[13] && !reg_wr |=> core_irq_req[13])
        else $error("bit13 lost");
    a_bit12_hold: assert property (core_irq_req[12] |=> core_irq_req[12] || $past(reg_wr))
        else $error("bit12 lost");
    a_bit0_cause: assert property ($rose(core_irq_req[0])
        |-> $past(ext_irq_first | reg_wr)) else $error("bit0 rose");
    a_bit6_cause: assert property ($rose(core_irq_req[6])
        |-> $past(dma_chan_first_irq | reg_wr)) else $error("bit6 rose");
    c_any: cover property (core_irq_any);
    c_bit6: cover property ($rose(core_irq_req[6]));
    c_read: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule // ifmb_chk
bind ifmb_bank ifmb_chk chk_u (.clk_sys, .arst_n, .reg_wr, .reg_rd, .ext_irq_first,
    .dma_chan_first_irq, .core_irq_any, .reg_addr, .reg_rdata, .core_irq_req);

// >>> sim/tb_top.sv
// bench of the flag/mask bank
// sources come from ifmb_src_model
`timescale 1ns/1ps
module tb_top;
    logic clk_sys = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, clk_en = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, d;
    logic [16:0] fire = 17'h00000;
    wire [16:0] s;
    wire [15:0] reg_rdata, core_irq_req;
    wire core_irq_any, irq_out;
    int fails = 0, num_checks = 0;
    int p0[17] = '{0, 1, 2, 8, 3, 7, 4, 5, 10, 11, 9, 16, 16, 16, 16, 12, 13};
    int p1[17] = '{0, 1, 2, 8, 3, 16, 4, 5, 16, 16, 9, 6, 7, 10, 11, 12, 13};
    ifmb_src_model src_u (.clk_sys, .fire, .src_q(s));
    ifmb_bank dut_u (.clk_sys, .arst_n, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .ext_irq_first(s[0]), .ext_irq_second(s[1]), .ext_irq_third(s[2]),
        .ext_irq_fourth(s[3]), .timer_a_irq(s[4]), .timer_b_irq(s[5]),
        .serial_port_a_rx_irq(s[6]), .serial_port_a_tx_irq(s[7]), .serial_port_b_rx_irq(s[8]),
        .serial_port_b_tx_irq(s[9]), .host_port_irq(s[10]), .dma_chan_first_irq(s[11]),
        .dma_chan_second_irq(s[12]), .dma_chan_third_irq(s[13]), .dma_chan_fourth_irq(s[14]),
        .dma_chan_fifth_irq(s[15]), .dma_chan_sixth_irq(s[16]), .core_irq_req, .core_irq_any,
        .irq_out);
    initial forever #5 clk_sys = ~clk_sys;
    initial #100000 results(1);
    task results(input int t);
        fails += t;
        $display("fails %0d checks %0d", fails, num_checks);
        if (fails == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        fails += (g !== e);
    endtask
    task op(input logic [3:0] a, input logic [15:0] v, input logic w);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, v, w, !w};
        @(posedge clk_sys);
        {reg_wr, reg_rd} <= 2'b00;
        #1 d = reg_rdata;
    endtask
    task hit(input int i);
        @(posedge clk_sys);
        fire <= 17'h00001 << i;
        @(posedge clk_sys);
        fire <= 17'h00000;
    endtask
    task t_rst;
        op(4'h2, 16'h0000, 1'b0);
        chk(d, 16'h0000);
        op(4'h1, 16'hFFFF, 1'b1);
        op(4'h1, 16'h0000, 1'b0);
        chk(d, 16'h3FBF);
        op(4'h7, 16'h0000, 1'b0);
        chk(d, 16'h0000);
    endtask
    task t_src(input logic [3:0] sel, input int p[17]);
        op(4'h2, {12'h000, sel}, 1'b1);
        op(4'h1, 16'hFFFF, 1'b1);
        for (int i = 0; i < 17; i++)
        begin
            hit(i);
            op(4'h0, 16'h0000, 1'b0);
            chk(d, 16'h0001 << p[i]);
            chk(core_irq_req, 16'h0001 << p[i]);
            chk({15'h0000, core_irq_any}, {15'h0000, p[i] < 16});
            op(4'h0, 16'hFFFF, 1'b1);
        end
    endtask
    task t_irq;
        op(4'h3, 16'h0000, 1'b0);
        op(4'h4, 16'h0001, 1'b1);
        hit(0);
        @(posedge clk_sys);
        #1 chk({15'h0000, irq_out}, 16'h0001);
        op(4'h3, 16'h0000, 1'b0);
        chk(d, 16'h0001);
        chk({15'h0000, irq_out}, 16'h0000);
        op(4'h1, 16'h0000, 1'b1);
        op(4'h4, 16'h0002, 1'b1);
        hit(1);
        @(posedge clk_sys);
        #1 chk({15'h0000, irq_out}, 16'h0001);
        op(4'h3, 16'h0000, 1'b0);
        chk(d, 16'h0002);
    endtask
    task t_frz;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        hit(2);
        repeat (2) @(posedge clk_sys);
        clk_en <= 1'b1;
        op(4'h0, 16'h0000, 1'b0);
        chk(d & 16'h0004, 16'h0000);
    endtask
    initial
    begin
        repeat (6) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_rst;
        t_src(4'h0, p0);
        t_src(4'hF, p1);
        t_irq;
        t_frz;
        results(0);
    end
endmodule // tb_top
